// ---- timer16_pkg.sv ----
`default_nettype none
package timer16_pkg;

   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [4:0] OFF_CTRL    = 5'h00; // control, write-only
   localparam logic [4:0] OFF_PERIOD  = 5'h04; // compare period
   localparam logic [4:0] OFF_CAPTURE = 5'h08; // capture / duty
   localparam logic [4:0] OFF_EDGE    = 5'h0C; // edge polarity select
   localparam logic [4:0] OFF_COUNT   = 5'h10; // live counter, read-only
   localparam logic [4:0] OFF_OUTFLOP = 5'h14; // output flop and run flag

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_SOFT_CAPTURE_BIT_BIT = 6;  // soft capture / edge count select
   localparam int CTRL_MSB      = 6;  // highest used control bit
   localparam int EDGE_POL_BIT  = 0;  // edge polarity select
   localparam int OUTFLOP_BIT   = 0;  // output flop value
   localparam int RUNFLAG_BIT   = 1;  // counter running or armed

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [15:0] PERIOD_RST  = 16'h0000;
   localparam logic [15:0] CAPTURE_RST = 16'h0000;
   localparam logic        OUTFLOP_RST = 1'h0;
   localparam logic        EDGE_RST    = 1'h0;

   // ****************************************
   // prescaler taps: clock divided by 2^n
   // ****************************************
   localparam int PRESC_W  = 11; // widest divider
   localparam int DIV_EXP0 = 11; // select 0
   localparam int DIV_EXP1 = 7;  // select 1
   localparam int DIV_EXP2 = 3;  // select 2, fine source
   localparam logic [1:0] SEL_FINE = 2'h2; // clock / 2^3

   // ****************************************
   // enumerations
   // ****************************************
   typedef enum logic [1:0] {
      MODE_EVENT, MODE_WINDOW, MODE_PWM, MODE_PPG
   } mode_t;
   typedef enum logic [1:0] {
      START_STOP, START_CMD, START_EXT, START_RSVD
   } start_t;
   typedef enum logic [1:0] {
      RUN_IDLE, RUN_WAIT, RUN_COUNT, RUN_SECOND
   } run_t;

   // control word, laid out as written on bits 6..0
   typedef struct packed {
      logic       edge_count_sel; // soft capture or edge count select
      start_t     start;          // timer1 start control
      mode_t      mode;           // operating mode
      logic [1:0] clk_sel;        // internal source select
   } ctrl_t;

endpackage : timer16_pkg
`default_nettype wire

// ---- clk_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// free-running divider of the system clock
// ****************************************
module clk_prescaler
   import timer16_pkg::*;
#(
   parameter int WIDTH = PRESC_W
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   output logic      [WIDTH-1:0] presc
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt; // bit k has period 2^(k+1)
   } presc_state_t;

   presc_state_t st_r;  // registered state
   presc_state_t st_nxt; // next state

   // advance by one each enabled cycle
   always_comb begin
      st_nxt = st_r;
      st_nxt.cnt = st_r.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
   end

   // register, frozen while ce is low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign presc = st_r.cnt;

endmodule : clk_prescaler
`default_nettype wire

// ---- timer16_event_window_pwm_capture.sv ----
`timescale 1ns/1ns
`default_nettype none

module timer16_event_window_pwm_capture
   import timer16_pkg::*;
#(
   parameter int ADDR_W = 5
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   input  wire logic              timer1_input_pin,
   output logic                   pulse_output_pin,
   output logic                   timer1_match_irq
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      ctrl_t       ctrl;     // control word
      logic        edge_pol; // edge polarity select
      logic [15:0] period;   // compare period register
      logic [15:0] capture;  // capture / duty register
      logic [15:0] cnt;      // up-counter
      run_t        run;      // counter phase
      logic        flop;     // output toggle flop
      logic        irq;      // match interrupt pulse
      logic        pin_q;    // previous pin sample
      logic        src_q;    // previous source level
      logic        gate_q;   // previous window product
      logic        waitreq;  // avalon waitrequest
      logic [31:0] rdata;    // avalon readdata
   } state_t;

   state_t st_r;   // registered state
   state_t st_nxt; // next state

   logic [PRESC_W-1:0] presc;     // divider taps
   logic               src_lvl;   // selected source level
   logic               src_tick;  // source rising edge
   logic               pin_act;   // pin at gating level
   logic               gate_rise; // rising edge of window product
   logic               trig_edge; // trigger-polarity edge
   logic               opp_edge;  // opposite edge
   logic               acc_wr;    // write taking effect this edge
   logic [15:0]        cap_val;   // value to capture

   // ****************************************
   // time base
   // ****************************************
   clk_prescaler #(
      .WIDTH (PRESC_W)
   ) u_presc (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .presc (presc)
   );

   // pick a divider tap as the internal source
   function automatic logic tap(input logic [1:0] sel,
                                input logic [PRESC_W-1:0] p);
      logic r;
      r = 1'b0;
      if (sel == 2'h0) begin
         r = p[DIV_EXP0-1];
      end else if (sel == 2'h1) begin
         r = p[DIV_EXP1-1];
      end else if (sel == SEL_FINE) begin
         r = p[DIV_EXP2-1];
      end
      return r;
   endfunction : tap

   // merge byte lanes into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = d[7:0];
      end
      if (be[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction : merge16

   // ****************************************
   // edge and source detection
   // ****************************************
   always_comb begin
      src_lvl   = tap(st_r.ctrl.clk_sel, presc);
      src_tick  = src_lvl & ~st_r.src_q;
      pin_act   = st_r.edge_pol ? ~timer1_input_pin : timer1_input_pin;
      gate_rise = (src_lvl & pin_act) & ~st_r.gate_q;
      trig_edge = st_r.edge_pol ? (~timer1_input_pin & st_r.pin_q)
                                : (timer1_input_pin & ~st_r.pin_q);
      opp_edge  = st_r.edge_pol ? (timer1_input_pin & ~st_r.pin_q)
                                : (~timer1_input_pin & st_r.pin_q);
      acc_wr    = write & ~st_r.waitreq;
      cap_val   = (st_r.ctrl.clk_sel == SEL_FINE)
                  ? {st_r.cnt[15:1], 1'b0} : st_r.cnt;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [15:0] inc;
      ctrl_t       c;
      inc = st_r.cnt + 16'h0001;
      c   = ctrl_t'(writedata[CTRL_MSB:0]);
      st_nxt        = st_r;
      st_nxt.irq    = 1'b0;
      st_nxt.pin_q  = timer1_input_pin;
      st_nxt.src_q  = src_lvl;
      st_nxt.gate_q = src_lvl & pin_act;
      st_nxt.waitreq = 1'b1;

      // counting per mode
      case (st_r.ctrl.mode)
         MODE_EVENT, MODE_WINDOW: begin
            if (st_r.run == RUN_COUNT &&
                ((st_r.ctrl.mode == MODE_EVENT) ? trig_edge : gate_rise)) begin
               if (inc == st_r.period) begin
                  st_nxt.cnt = 16'h0000;
                  st_nxt.irq = 1'b1;
               end else begin
                  st_nxt.cnt = inc;
               end
            end
         end
         MODE_PWM: begin
            case (st_r.run)
               RUN_WAIT: begin
                  if (trig_edge) begin
                     st_nxt.cnt = 16'h0000;
                     st_nxt.run = RUN_COUNT;
                  end
               end
               RUN_COUNT: begin
                  if (opp_edge) begin
                     st_nxt.capture = cap_val;
                     st_nxt.irq     = 1'b1;
                     if (st_r.ctrl.edge_count_sel) begin
                        st_nxt.run = RUN_SECOND;
                        st_nxt.cnt = src_tick ? inc : st_r.cnt;
                     end else begin
                        st_nxt.cnt = 16'h0000;
                        st_nxt.run = RUN_WAIT;
                     end
                  end else if (src_tick) begin
                     st_nxt.cnt = inc;
                  end
               end
               RUN_SECOND: begin
                  if (trig_edge) begin
                     st_nxt.capture = cap_val;
                     st_nxt.cnt     = 16'h0000;
                     st_nxt.run     = RUN_COUNT;
                  end else if (src_tick) begin
                     st_nxt.cnt = inc;
                  end
               end
               default: begin
                  st_nxt.run = st_r.run;
               end
            endcase
         end
         MODE_PPG: begin
            if (st_r.run == RUN_WAIT && trig_edge) begin
               st_nxt.run = RUN_COUNT;
            end else if (st_r.run == RUN_COUNT && src_tick) begin
               if (inc == st_r.period) begin
                  st_nxt.cnt  = 16'h0000;
                  st_nxt.flop = ~st_r.flop;
                  st_nxt.irq  = 1'b1;
               end else begin
                  st_nxt.cnt = inc;
                  if (inc == st_r.capture) begin
                     st_nxt.flop = ~st_r.flop;
                  end
               end
            end
         end
         default: begin
            st_nxt.run = st_r.run;
         end
      endcase

      // bus: first edge of a request loads data, drops waitrequest
      if ((read | write) & st_r.waitreq) begin
         st_nxt.waitreq = 1'b0;
         st_nxt.rdata   = 32'h0000_0000;
         if (read) begin
            if (address == ADDR_W'(OFF_CTRL)) begin
               st_nxt.rdata = 32'h0000_0000;
            end else if (address == ADDR_W'(OFF_PERIOD)) begin
               st_nxt.rdata = {16'h0000, st_r.period};
            end else if (address == ADDR_W'(OFF_CAPTURE)) begin
               st_nxt.rdata = {16'h0000, st_r.capture};
            end else if (address == ADDR_W'(OFF_EDGE)) begin
               st_nxt.rdata[EDGE_POL_BIT] = st_r.edge_pol;
            end else if (address == ADDR_W'(OFF_COUNT)) begin
               st_nxt.rdata = {16'h0000, st_r.cnt};
            end else if (address == ADDR_W'(OFF_OUTFLOP)) begin
               st_nxt.rdata[OUTFLOP_BIT] = st_r.flop;
               st_nxt.rdata[RUNFLAG_BIT] = (st_r.run != RUN_IDLE);
            end
         end
      end

      // bus: write takes effect at the edge that sees waitrequest low
      if (acc_wr) begin
         if (address == ADDR_W'(OFF_CTRL)) begin
            if (byteenable[0]) begin
               if (st_r.ctrl.mode inside {MODE_EVENT, MODE_WINDOW} &&
                   c.mode inside {MODE_EVENT, MODE_WINDOW} &&
                   writedata[CTRL_SOFT_CAPTURE_BIT_BIT]) begin
                  st_nxt.capture = st_r.cnt;
                  c.edge_count_sel = 1'b0;
               end
               st_nxt.ctrl = c;
               if (c.start == START_STOP) begin
                  st_nxt.run = RUN_IDLE;
                  st_nxt.cnt = 16'h0000;
               end else if (st_r.ctrl.start == START_STOP) begin
                  st_nxt.run = (c.mode == MODE_PWM ||
                                (c.mode == MODE_PPG && c.start == START_EXT))
                               ? RUN_WAIT : RUN_COUNT;
                  st_nxt.cnt = 16'h0000;
               end
            end
         end else if (address == ADDR_W'(OFF_PERIOD)) begin
            st_nxt.period = merge16(st_r.period, writedata, byteenable);
         end else if (address == ADDR_W'(OFF_CAPTURE)) begin
            if (st_r.ctrl.mode == MODE_PPG) begin
               st_nxt.capture = merge16(st_r.capture, writedata, byteenable);
            end
         end else if (address == ADDR_W'(OFF_EDGE)) begin
            if (byteenable[0]) begin
               st_nxt.edge_pol = writedata[EDGE_POL_BIT];
            end
         end else if (address == ADDR_W'(OFF_OUTFLOP)) begin
            if (byteenable[0]) begin
               st_nxt.flop = writedata[OUTFLOP_BIT];
            end
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r          <= '0;
         st_r.period   <= PERIOD_RST;
         st_r.capture  <= CAPTURE_RST;
         st_r.edge_pol <= EDGE_RST;
         st_r.flop     <= OUTFLOP_RST;
         st_r.run      <= RUN_IDLE;
         st_r.waitreq  <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops
   assign readdata         = st_r.rdata;
   assign waitrequest      = st_r.waitreq;
   assign pulse_output_pin = st_r.flop;
   assign timer1_match_irq = st_r.irq;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_event_count;
      ce && st_r.ctrl.mode == MODE_EVENT && st_r.run == RUN_COUNT &&
      trig_edge && !acc_wr && st_r.cnt + 16'h0001 != st_r.period
      |=> st_r.cnt == $past(st_r.cnt) + 16'h0001;
   endproperty
   a_event_count: assert property (p_event_count)
      else $error("event edge did not advance the counter");

   property p_match_irq;
      ce && st_r.ctrl.mode == MODE_EVENT && st_r.run == RUN_COUNT &&
      trig_edge && !acc_wr && st_r.cnt + 16'h0001 == st_r.period
      |=> timer1_match_irq && st_r.cnt == 16'h0000;
   endproperty
   a_match_irq: assert property (p_match_irq)
      else $error("period match without irq and clear");

   property p_soft_capture;
      ce && acc_wr && address == ADDR_W'(OFF_CTRL) && byteenable[0] &&
      writedata[CTRL_SOFT_CAPTURE_BIT_BIT] && st_r.ctrl.mode == MODE_EVENT &&
      writedata[3:2] == 2'h0
      |=> st_r.capture == $past(st_r.cnt) && !st_r.ctrl.edge_count_sel;
   endproperty
   a_soft_capture: assert property (p_soft_capture)
      else $error("soft capture did not copy counter");

   property p_window_gate;
      ce && st_r.ctrl.mode == MODE_WINDOW && st_r.run == RUN_COUNT &&
      !acc_wr && !pin_act
      |=> st_r.cnt == $past(st_r.cnt);
   endproperty
   a_window_gate: assert property (p_window_gate)
      else $error("window counted while gate closed");

   property p_pwm_capture;
      ce && st_r.ctrl.mode == MODE_PWM && st_r.run == RUN_COUNT &&
      opp_edge && !acc_wr
      |=> timer1_match_irq && st_r.capture == $past(cap_val);
   endproperty
   a_pwm_capture: assert property (p_pwm_capture)
      else $error("opposite edge missed capture or irq");

   property p_single_edge;
      ce && st_r.ctrl.mode == MODE_PWM && st_r.run == RUN_COUNT &&
      opp_edge && !acc_wr && !st_r.ctrl.edge_count_sel
      |=> st_r.cnt == 16'h0000 && st_r.run == RUN_WAIT;
   endproperty
   a_single_edge: assert property (p_single_edge)
      else $error("single edge capture did not clear");

   property p_fine_lsb;
      ce && st_r.ctrl.mode == MODE_PWM && st_r.run == RUN_COUNT &&
      opp_edge && !acc_wr && st_r.ctrl.clk_sel == SEL_FINE
      |=> !st_r.capture[0];
   endproperty
   a_fine_lsb: assert property (p_fine_lsb)
      else $error("fine source capture LSB not zero");

   property p_ppg_duty;
      ce && st_r.ctrl.mode == MODE_PPG && st_r.run == RUN_COUNT &&
      src_tick && !acc_wr && st_r.cnt + 16'h0001 == st_r.capture &&
      st_r.cnt + 16'h0001 != st_r.period
      |=> pulse_output_pin != $past(pulse_output_pin);
   endproperty
   a_ppg_duty: assert property (p_ppg_duty)
      else $error("duty match did not toggle output");

   property p_preset;
      ce && acc_wr && address == ADDR_W'(OFF_OUTFLOP) && byteenable[0]
      |=> pulse_output_pin == $past(writedata[OUTFLOP_BIT]);
   endproperty
   a_preset: assert property (p_preset)
      else $error("output flop preset lost");

   property p_capture_lock;
      ce && acc_wr && address == ADDR_W'(OFF_CAPTURE) &&
      st_r.ctrl.mode == MODE_EVENT
      |=> st_r.capture == $past(st_r.capture);
   endproperty
   a_capture_lock: assert property (p_capture_lock)
      else $error("capture written outside pulse mode");

   property p_ctrl_wo;
      ce && read && st_r.waitreq && address == ADDR_W'(OFF_CTRL)
      |=> readdata == 32'h0000_0000 && !waitrequest;
   endproperty
   a_ctrl_wo: assert property (p_ctrl_wo)
      else $error("control register read back nonzero");

   property p_irq_pulse;
      ce && timer1_match_irq && st_r.period != 16'h0000 ##1 ce
      |-> !timer1_match_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("irq held beyond one cycle");

   c_event_irq: cover property (st_r.ctrl.mode == MODE_EVENT &&
                                timer1_match_irq);
   c_pwm_double: cover property (st_r.run == RUN_SECOND && trig_edge);
   c_ppg_toggle: cover property (st_r.ctrl.mode == MODE_PPG &&
                                 $changed(pulse_output_pin));
   c_window_irq: cover property (st_r.ctrl.mode == MODE_WINDOW &&
                                 timer1_match_irq);

endmodule : timer16_event_window_pwm_capture
`default_nettype wire

// ---- pulse_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// external pulse source on the timer input
// ****************************************
module pulse_src (
   input  wire logic       clk,  // system clock
   input  wire logic       go,   // start a burst
   input  wire logic [7:0] n,    // pulses in burst
   input  wire logic [7:0] len,  // cycles per level
   output logic            pin,  // drives timer input
   output logic            busy  // burst in progress
);
   int cnt = 0; // cycles left in burst
   // burst countdown
   always @(posedge clk) begin
      if (go && cnt == 0) cnt <= 2 * n * len;
      else if (cnt != 0) cnt <= cnt - 1;
   end
   assign busy = (cnt != 0);
   assign pin = busy && (((cnt - 1) / len) % 2 == 1);
endmodule : pulse_src
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
   import timer16_pkg::*;
   logic        clk = 0, rst_b = 0, read = 0, write = 0, go = 0;
   logic [4:0]  address = 0;
   logic [31:0] writedata = 0, readdata, q, c1;
   logic [7:0]  np = 0, ln = 8;
   logic        waitrequest, pin, busy, pout, irq, prev;
   int          err_total = 0, n_tests = 0, irq_n = 0, b, tg;
   timer16_event_window_pwm_capture dut (.clk(clk), .rst_b(rst_b),
      .ce(1'b1), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .timer1_input_pin(pin),
      .pulse_output_pin(pout), .timer1_match_irq(irq));
   pulse_src src (.clk(clk), .go(go), .n(np), .len(ln), .pin(pin),
      .busy(busy));
   // ****************************************
   // clock, irq counter, checks, bus
   // ****************************************
   initial forever #2 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   // one avalon cycle, entered just after a rising edge
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      // wait for the slave however long; the watchdog ends a hang
      do begin @(posedge clk); end
      while (waitrequest !== 1'b0);
      q = readdata;
      read <= 0;
      write <= 0;
      @(posedge clk);
   endtask : bus
   task send(input logic [7:0] n, input logic [7:0] l);
      np <= n;
      ln <= l;
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (2 * n * l + 4) @(posedge clk);
   endtask : send
   // ****************************************
   // scenarios
   // ****************************************
   task t_reset;
      bus(0, OFF_PERIOD, 0); chk(q, {16'h0, PERIOD_RST});
      bus(0, OFF_OUTFLOP, 0); chk(q, 32'h0);
      bus(1, OFF_CTRL, 32'h03); bus(0, OFF_CTRL, 0); chk(q, 32'h0);
      bus(0, 5'h18, 0); chk(q, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task t_event;
      bus(1, OFF_EDGE, 0); bus(1, OFF_PERIOD, 3); bus(1, OFF_CTRL, 32'h10);
      b = irq_n;
      send(2, 8); bus(0, OFF_COUNT, 0); chk(q, 32'h2);
      send(1, 8); bus(0, OFF_COUNT, 0); chk(q, 32'h0);
      chk(irq_n - b, 1);
      bus(1, OFF_EDGE, 1); send(1, 8);
      bus(1, OFF_CTRL, 32'h50); bus(0, OFF_CAPTURE, 0);
      chk(q, 32'h1);
      bus(1, OFF_CAPTURE, 9); bus(0, OFF_CAPTURE, 0); chk(q, 32'h1);
      $display("event test done");
   endtask : t_event
   task t_window;
      bus(1, OFF_CTRL, 0); bus(1, OFF_EDGE, 0);
      bus(1, OFF_PERIOD, 32'hFFFF); bus(1, OFF_CTRL, 32'h16);
      repeat (40) @(posedge clk);
      bus(0, OFF_COUNT, 0); chk(q, 32'h0);
      send(1, 64); bus(0, OFF_COUNT, 0);
      chk(q >= 7 && q <= 9, 1);
      bus(1, OFF_EDGE, 1); bus(0, OFF_COUNT, 0); c1 = q;
      repeat (40) @(posedge clk);
      bus(0, OFF_COUNT, 0); chk(q > c1, 1);
      $display("window test done");
   endtask : t_window
   task t_width;
      bus(1, OFF_CTRL, 0); bus(1, OFF_EDGE, 0); bus(1, OFF_CTRL, 32'h2A);
      b = irq_n;
      send(1, 64); bus(0, OFF_CAPTURE, 0);
      chk(q[0], 0);
      chk(q >= 6 && q <= 9, 1);
      chk(irq_n - b, 1);
      // double edge: first capture read before the next trigger edge
      bus(1, OFF_CTRL, 0); bus(1, OFF_CTRL, 32'h6A);
      send(1, 64); bus(0, OFF_CAPTURE, 0);
      chk(q >= 6 && q <= 9, 1);
      bus(0, OFF_COUNT, 0); chk(q >= 14 && q <= 18, 1);
      // falling trigger: low width first, then full period recaptured
      bus(1, OFF_CTRL, 0); bus(1, OFF_EDGE, 1); bus(1, OFF_CTRL, 32'h6A);
      b = irq_n;
      send(2, 64); bus(0, OFF_CAPTURE, 0);
      chk(q >= 14 && q <= 18, 1);
      chk(irq_n - b, 1);
      $display("width test done");
   endtask : t_width
   task t_ppg;
      bus(1, OFF_CTRL, 0); bus(1, OFF_CTRL, 32'h0E); bus(1, OFF_PERIOD, 4);
      bus(1, OFF_CAPTURE, 2); bus(0, OFF_CAPTURE, 0); chk(q, 32'h2);
      // pin driven from the output flop, preset high
      bus(1, OFF_OUTFLOP, 1); chk(pout, 1);
      b = irq_n;
      tg = 0;
      prev = pout;
      bus(1, OFF_CTRL, 32'h1E);
      repeat (320) begin
         @(posedge clk);
         if (pout !== prev) tg++;
         prev = pout;
      end
      chk(tg >= 18 && tg <= 21, 1);
      chk(irq_n - b >= 9 && irq_n - b <= 11, 1);
      // armed for a falling edge, no count before it
      bus(1, OFF_CTRL, 0); bus(1, OFF_CTRL, 32'h2E);
      b = irq_n;
      repeat (100) @(posedge clk);
      chk(irq_n - b, 0);
      send(1, 8);
      repeat (100) @(posedge clk);
      chk(irq_n - b >= 2, 1);
      $display("pulse test done");
   endtask : t_ppg
   // ****************************************
   // verdict, main sequence, watchdog
   // ****************************************
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      t_reset; t_event; t_window; t_width; t_ppg;
      wrap_up;
   end
   initial begin
      #200000;
      err_total++;
      wrap_up;
   end
endmodule : tb
`default_nettype wire
